/* issu_unit.sv */
/*
  Integer shift/subtract execute lane with the issue-group
  break check for a two-wide front end. Assumes operands arrive
  with the slot 0 instruction and the register file writes on
  wr_en_q. One clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module issu_unit
  import issu_pkg::*;
#(
  parameter bit MULTI_ISSUE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue group from decode
  input wire logic slot0_valid,
  input wire logic [WORD_W-1:0] slot0_instr,
  input wire logic slot1_valid,
  input wire logic [WORD_W-1:0] slot1_instr,
  input wire logic lane_ready,
  output logic slot0_take,
  output logic slot1_take,
  // Operands for slot 0
  input wire logic [WORD_W-1:0] src_val,
  input wire logic [WORD_W-1:0] snd_val,
  // Result towards the register file
  output logic [WORD_W-1:0] result_q,
  output logic [REG_W-1:0] dst_q,
  output logic wr_en_q,
  // Completion and exceptions
  output logic done_q,
  output logic int_ovf_q,
  output logic foreign_q
);

  // ==========================================================
  // Decoding
  function automatic logic is_brk(input logic [WORD_W-1:0] ins);
    is_brk = (ins == BRK_WORD);
  endfunction : is_brk

  function automatic issu_op_t decode(input logic [WORD_W-1:0] ins);
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] src;
    logic [4:0] amt;
    opc = ins[OPC_LSB +: 6];
    fn = ins[FN_LSB +: FN_W];
    src = ins[SRC_LSB +: REG_W];
    amt = ins[AMT_LSB +: REG_W];
    decode = OP_FOREIGN;
    if (opc == OPC_FUNC_GRP) begin
      unique case (fn)
        FN_ASR_IMM: begin
          if (src == ZERO5) decode = OP_ASR_IMM;
        end
        FN_ASR_VAR: begin
          if (amt == ZERO5) decode = OP_ASR_VAR;
        end
        FN_LSR_IMM: begin
          if (src[4:1] == ZERO4 && !ins[ROT_BIT]) decode = OP_LSR_IMM;
        end
        FN_LSR_VAR: begin
          if (amt[4:1] == ZERO4 && !ins[VROT_BIT]) decode = OP_LSR_VAR;
        end
        FN_SUB: begin
          if (amt == ZERO5) decode = OP_SUB;
        end
        FN_WRAP_SUB: begin
          if (amt == ZERO5) decode = OP_WRAP_SUB;
        end
        FN_SHL_IMM: begin
          if (is_brk(ins)) decode = OP_BRK;
        end
        default: decode = OP_FOREIGN;
      endcase
    end
  endfunction : decode

  issu_op_t op0;
  logic brk0;
  logic brk1;

  assign op0 = decode(slot0_instr);
  assign brk0 = is_brk(slot0_instr);
  assign brk1 = is_brk(slot1_instr);

  // ==========================================================
  // Issue group formation
  // Slot 0 never waits on the no-op check, so it costs no cycle.
  assign slot0_take = slot0_valid & lane_ready;

  // A no-op in either slot stops pairing: before it, or after it.
  assign slot1_take = MULTI_ISSUE & slot0_take & slot1_valid
    & !brk0 & !brk1;

  // ==========================================================
  // Datapath
  logic sh_arith;
  logic sh_var;
  logic [REG_W-1:0] sh_amt;
  logic [WORD_W-1:0] sh_res;
  logic [WORD_W-1:0] sub_diff;
  logic sub_ovf;

  assign sh_arith = (op0 == OP_ASR_IMM) || (op0 == OP_ASR_VAR);
  assign sh_var = (op0 == OP_ASR_VAR) || (op0 == OP_LSR_VAR);
  // Upper bits of the count register are deliberately dropped.
  assign sh_amt = sh_var ? src_val[REG_W-1:0]
    : slot0_instr[AMT_LSB +: REG_W];

  issu_shift #(
    .W(WORD_W),
    .AW(REG_W)
  ) u_shift (
    .value(snd_val),
    .amount(sh_amt),
    .arith(sh_arith),
    .result(sh_res)
  );

  issu_sub #(
    .W(WORD_W)
  ) u_sub (
    .minuend(src_val),
    .subtrahend(snd_val),
    .diff(sub_diff),
    .ovf(sub_ovf)
  );

  // ==========================================================
  // Next-state of the result stage
  logic [WORD_W-1:0] result_d;
  logic [REG_W-1:0] dst_d;
  logic wr_en_d;
  logic ovf_d;

  always_comb begin
    result_d = RES_RST;
    dst_d = slot0_instr[DST_LSB +: REG_W];
    wr_en_d = 1'b0;
    ovf_d = 1'b0;
    unique case (op0)
      OP_ASR_IMM, OP_ASR_VAR, OP_LSR_IMM, OP_LSR_VAR: begin
        result_d = sh_res;
        wr_en_d = 1'b1;
      end
      OP_SUB: begin
        result_d = sub_diff;
        // Faulting subtract must not touch the destination.
        wr_en_d = !sub_ovf;
        ovf_d = sub_ovf;
      end
      OP_WRAP_SUB: begin
        result_d = sub_diff;
        wr_en_d = 1'b1;
      end
      OP_BRK: begin
        dst_d = DST_RST;
      end
      OP_FOREIGN: begin
        dst_d = DST_RST;
      end
    endcase
  end

  // ==========================================================
  // Result stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= RES_RST;
      dst_q <= DST_RST;
    end else if (slot0_take) begin
      result_q <= result_d;
      dst_q <= dst_d;
    end
  end

  // Flag and write gate leave from one edge together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_en_q <= 1'b0;
      int_ovf_q <= 1'b0;
    end else begin
      wr_en_q <= slot0_take & wr_en_d;
      int_ovf_q <= slot0_take & ovf_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      foreign_q <= 1'b0;
    end else begin
      done_q <= slot0_take && (op0 != OP_FOREIGN);
      foreign_q <= slot0_take && (op0 == OP_FOREIGN);
    end
  end

  // ==========================================================
  // Checks
  logic [WORD_W-1:0] exp_asr_imm;
  logic [WORD_W-1:0] exp_asr_var;
  logic [WORD_W-1:0] exp_lsr_imm;
  logic [WORD_W-1:0] exp_lsr_var;
  logic [WORD_W-1:0] exp_diff;
  logic exp_ovf;
  logic [32:0] exp_wide;

  assign exp_asr_imm = WORD_W'($signed(snd_val) >>> slot0_instr[10:6]);
  assign exp_asr_var = WORD_W'($signed(snd_val) >>> src_val[4:0]);
  assign exp_lsr_imm = snd_val >> slot0_instr[10:6];
  assign exp_lsr_var = snd_val >> src_val[4:0];
  assign exp_wide = {src_val[31], src_val} - {snd_val[31], snd_val};
  assign exp_diff = exp_wide[31:0];
  assign exp_ovf = exp_wide[32] != exp_wide[31];

  a_asr_sign_fill: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_ASR_IMM |=> wr_en_q && result_q == $past(exp_asr_imm)
  ) else $error("immediate arithmetic shift result wrong");

  a_asr_low_count: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_ASR_VAR |=> wr_en_q && result_q == $past(exp_asr_var)
  ) else $error("variable arithmetic shift result wrong");

  a_lsr_zero_fill: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_LSR_IMM |=> wr_en_q && result_q == $past(exp_lsr_imm)
  ) else $error("immediate logical shift result wrong");

  a_lsrv_zero_fill: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_LSR_VAR |=> wr_en_q && result_q == $past(exp_lsr_var)
  ) else $error("variable logical shift result wrong");

  a_asrv_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && slot0_instr[31:26] == 6'h00 && slot0_instr[5:0] == 6'h07
      && slot0_instr[10:6] != 5'h00 |=> foreign_q && !wr_en_q
  ) else $error("malformed variable shift was accepted");

  a_lsr_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && slot0_instr[31:26] == 6'h00 && slot0_instr[5:0] == 6'h02
      && slot0_instr[25:21] != 5'h00 |=> foreign_q && !wr_en_q
  ) else $error("malformed logical shift was accepted");

  a_asr_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && slot0_instr[31:26] == 6'h00 && slot0_instr[5:0] == 6'h03
      |-> (op0 == OP_ASR_IMM) == (slot0_instr[25:21] == 5'h00)
  ) else $error("arithmetic shift decode wrong");

  a_brk_no_pair: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot1_valid && slot1_instr == 32'h00000040 |-> !slot1_take
  ) else $error("issue-break no-op paired with earlier instruction");

  a_brk_alone: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && slot0_instr == 32'h00000040 |-> !slot1_take
      ##1 done_q && !wr_en_q && !int_ovf_q
  ) else $error("issue-break no-op did not issue alone");

  a_no_extra_wait: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_valid && lane_ready |-> slot0_take
  ) else $error("issue held back without cause");

  a_single_issue: assert property (
    @(posedge clk) disable iff (!rst_b)
    !MULTI_ISSUE |-> !slot1_take
  ) else $error("second slot used on single-issue core");

  a_sub_trap: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_SUB |=>
      (int_ovf_q == $past(exp_ovf)) && (wr_en_q != int_ovf_q)
      && (wr_en_q -> result_q == $past(exp_diff))
  ) else $error("trapping subtract result or trap wrong");

  a_sub_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && slot0_instr[31:26] == 6'h00 && slot0_instr[5:0] == 6'h22
      && slot0_instr[10:6] != 5'h00 |=> foreign_q && !int_ovf_q
  ) else $error("malformed trapping subtract accepted");

  a_wrap_sub: assert property (
    @(posedge clk) disable iff (!rst_b)
    slot0_take && op0 == OP_WRAP_SUB |=>
      wr_en_q && !int_ovf_q && result_q == $past(exp_diff)
  ) else $error("wrapping subtract result or trap wrong");

  a_ovf_gates_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    int_ovf_q |-> !wr_en_q && done_q
  ) else $error("overflow flag and write gate out of step");

  a_ovf_cause: assert property (
    @(posedge clk) disable iff (!rst_b)
    int_ovf_q |-> $past(op0) == OP_SUB && $past(exp_ovf)
  ) else $error("overflow raised without a cause");

  a_brk_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    (op0 == OP_BRK) == (slot0_instr == 32'h00000040)
  ) else $error("issue-break no-op decode wrong");

endmodule : issu_unit

/* issu_pkg.sv */
/*
  Constants, field layout and operation codes for the integer
  shift/subtract lane. Assumes a 32-bit instruction word in the
  usual six-field register format.
*/
package issu_pkg;

  // ==========================================================
  // Data widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned REG_W = 5;
  localparam int unsigned FN_W = 6;
  localparam int unsigned SIGN_BIT = 31;

  // ==========================================================
  // Instruction field positions (low bit of each field)
  localparam int unsigned OPC_LSB = 26;
  localparam int unsigned SRC_LSB = 21;
  localparam int unsigned SND_LSB = 16;
  localparam int unsigned DST_LSB = 11;
  localparam int unsigned AMT_LSB = 6;
  localparam int unsigned FN_LSB = 0;
  localparam int unsigned ROT_BIT = 21;
  localparam int unsigned VROT_BIT = 6;

  // ==========================================================
  // Encodings
  localparam logic [5:0] OPC_FUNC_GRP = 6'h00;
  localparam logic [5:0] FN_SHL_IMM = 6'h00;
  localparam logic [5:0] FN_LSR_IMM = 6'h02;
  localparam logic [5:0] FN_ASR_IMM = 6'h03;
  localparam logic [5:0] FN_LSR_VAR = 6'h06;
  localparam logic [5:0] FN_ASR_VAR = 6'h07;
  localparam logic [5:0] FN_SUB = 6'h22;
  localparam logic [5:0] FN_WRAP_SUB = 6'h23;
  localparam logic [4:0] ZERO5 = 5'h00;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [31:0] BRK_WORD = 32'h00000040;

  // ==========================================================
  // Reset values of the result stage
  localparam logic [31:0] RES_RST = 32'h00000000;
  localparam logic [4:0] DST_RST = 5'h00;

  // ==========================================================
  // Decoded operation
  typedef enum logic [3:0] {
    OP_FOREIGN = 4'h0,
    OP_ASR_IMM = 4'h1,
    OP_ASR_VAR = 4'h2,
    OP_LSR_IMM = 4'h3,
    OP_LSR_VAR = 4'h4,
    OP_SUB = 4'h5,
    OP_WRAP_SUB = 4'h6,
    OP_BRK = 4'h7
  } issu_op_t;

endpackage : issu_pkg

/* issu_shift.sv */
/*
  Right shifter, logical or arithmetic, built as a log-depth
  barrel. Assumes the shift amount is already limited to 5 bits.
*/
`timescale 1ns/100ps
module issu_shift
  import issu_pkg::*;
#(
  parameter int unsigned W = WORD_W,
  parameter int unsigned AW = REG_W
) (
  // Operand and control
  input wire logic [W-1:0] value,
  input wire logic [AW-1:0] amount,
  input wire logic arith,
  // Result
  output logic [W-1:0] result
);

  logic fill;
  logic [W-1:0] stage [AW+1];

  assign fill = arith & value[W-1];
  assign stage[0] = value;

  // ==========================================================
  // One stage per amount bit
  for (genvar i = 0; i < AW; i++) begin : g_stage
    localparam int unsigned SH = 1 << i;
    assign stage[i+1] = amount[i]
      ? {{SH{fill}}, stage[i][W-1:SH]}
      : stage[i];
  end

  assign result = stage[AW];

endmodule : issu_shift

/* issu_sub.sv */
/*
  Word subtractor with signed overflow detection by a one-bit
  sign extension. Assumes two's complement operands.
*/
`timescale 1ns/100ps
module issu_sub
  import issu_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  // Operands
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  // Result
  output logic [W-1:0] diff,
  output logic ovf
);

  logic [W:0] wide;

  // ==========================================================
  // Extended difference; top two bits disagree on overflow
  assign wide = {minuend[W-1], minuend} - {subtrahend[W-1], subtrahend};
  assign diff = wide[W-1:0];
  assign ovf = wide[W] ^ wide[W-1];

endmodule : issu_sub

/* issu_rf.sv */
/*
  Register file model standing beside the shift/subtract lane:
  reads the two operand registers of the slot 0 word, writes back.
  Assumes the lane's result registers drive the write port.
*/
`timescale 1ns/100ps
module issu_rf
  import issu_pkg::*;
(
  // Clock
  input wire logic clk,
  // Read side
  input wire logic valid,
  input wire logic [WORD_W-1:0] instr,
  output logic [WORD_W-1:0] src_val,
  output logic [WORD_W-1:0] snd_val,
  // Write side
  input wire logic wr_en,
  input wire logic [REG_W-1:0] dst,
  input wire logic [WORD_W-1:0] wdata
);
  logic [WORD_W-1:0] regs [32];

  // ==========================================================
  // Read ports
  // Idle ports show junk, not a stale operand
  assign src_val = !valid ? ~instr : (instr[25:21] == 5'h00) ? 32'h0 : regs[instr[25:21]];
  assign snd_val = !valid ? instr : (instr[20:16] == 5'h00) ? 32'h0 : regs[instr[20:16]];

  // ==========================================================
  // Write port; register zero stays zero
  always @(posedge clk) begin
    if (wr_en && dst != 5'h00) begin
      regs[dst] <= wdata;
    end
  end
endmodule : issu_rf

/* issu_unit_tb.sv */
/*
  Self-checking bench for the shift/subtract lane: corner cases,
  then seeded random issue groups. Assumes one 25 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module issu_unit_tb;
  import issu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic slot0_valid = 1'b0;
  logic [31:0] slot0_instr = 32'h0;
  logic slot1_valid = 1'b0;
  logic [31:0] slot1_instr = 32'h0;
  logic lane_ready = 1'b0;
  logic slot0_take, slot1_take, wr_en_q, done_q, int_ovf_q, foreign_q;
  logic [31:0] src_val, snd_val, result_q;
  logic [4:0] dst_q;
  logic slot1_take_si;
  int err_total = 0;
  int checks = 0;
  logic [31:0] seed = 32'hB9D5F07A;
  logic [31:0] e_res;
  logic [4:0] e_dst;
  logic e_wr = 1'b0;
  logic e_done = 1'b0;
  logic e_ovf = 1'b0;
  logic e_frn = 1'b0;
  logic e_brk = 1'b0;

  always #20 clk = ~clk;

  issu_unit u_dut (.clk(clk), .rst_b(rst_b), .slot0_valid(slot0_valid),
    .slot0_instr(slot0_instr), .slot1_valid(slot1_valid), .slot1_instr(slot1_instr),
    .lane_ready(lane_ready), .slot0_take(slot0_take), .slot1_take(slot1_take),
    .src_val(src_val), .snd_val(snd_val), .result_q(result_q), .dst_q(dst_q),
    .wr_en_q(wr_en_q), .done_q(done_q), .int_ovf_q(int_ovf_q), .foreign_q(foreign_q));

  issu_rf u_rf (.clk(clk), .valid(slot0_valid), .instr(slot0_instr), .src_val(src_val),
    .snd_val(snd_val), .wr_en(wr_en_q), .dst(dst_q), .wdata(result_q));

  // Single-issue twin on the same stimulus: second slot must stay unused
  issu_unit #(.MULTI_ISSUE(1'b0)) u_dut_si (.clk(clk), .rst_b(rst_b),
    .slot0_valid(slot0_valid), .slot0_instr(slot0_instr), .slot1_valid(slot1_valid),
    .slot1_instr(slot1_instr), .lane_ready(lane_ready), .slot0_take(),
    .slot1_take(slot1_take_si), .src_val(src_val), .snd_val(snd_val), .result_q(),
    .dst_q(), .wr_en_q(), .done_q(), .int_ovf_q(), .foreign_q());

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] mk(logic [4:0] s, logic [4:0] t, logic [4:0] d,
                                     logic [4:0] amt, logic [5:0] fn);
    return {6'h00, s, t, d, amt, fn};
  endfunction : mk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // One issue cycle; checks the previous cycle's answer first
  task automatic issue(logic v0, logic [31:0] i, logic v1, logic [31:0] i1, logic rdy);
    logic [31:0] a, b;
    logic [32:0] t33;
    logic [4:0] amt;
    logic ok;
    @(negedge clk);
    `CHK({wr_en_q, done_q, int_ovf_q, foreign_q}, {e_wr, e_done, e_ovf, e_frn})
    if (e_wr) begin
      `CHK(result_q, e_res)
      `CHK(dst_q, e_dst)
    end
    if (e_brk) begin
      `CHK(dst_q, 5'h00)
    end
    slot0_valid = v0;
    slot0_instr = i;
    slot1_valid = v1;
    slot1_instr = i1;
    lane_ready = rdy;
    #1;
    a = src_val;
    b = snd_val;
    amt = i[10:6];
    t33 = {a[31], a} - {b[31], b};
    {e_wr, e_done, e_ovf, e_frn, e_brk} = 5'h00;
    e_dst = i[15:11];
    `CHK(slot0_take, v0 & rdy)
    `CHK(slot1_take, v0 & rdy & v1 & (i != BRK_WORD) & (i1 != BRK_WORD))
    `CHK(slot1_take_si, 1'b0)
    if (v0 && rdy) begin
      ok = (i[31:26] == OPC_FUNC_GRP);
      case (i[5:0])
        FN_ASR_IMM: begin ok &= (i[25:21] == 5'h00); e_res = $signed(b) >>> amt; end
        FN_ASR_VAR: begin ok &= (amt == 5'h00); e_res = $signed(b) >>> a[4:0]; end
        FN_LSR_IMM: begin ok &= (i[25:21] == 5'h00); e_res = b >> amt; end
        FN_LSR_VAR: begin ok &= (amt == 5'h00); e_res = b >> a[4:0]; end
        FN_SUB, FN_WRAP_SUB: begin ok &= (amt == 5'h00); e_res = t33[31:0]; end
        default: ok = 1'b0;
      endcase
      if (i == BRK_WORD) begin
        e_done = 1'b1;
        e_brk = 1'b1;
      end else if (!ok) begin
        e_frn = 1'b1;
      end else begin
        e_done = 1'b1;
        e_ovf = (i[5:0] == FN_SUB) && (t33[32] != t33[31]);
        e_wr = !e_ovf;
      end
    end
  endtask : issue

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] w, i;
    logic [5:0] fnt [8];
    fnt = '{FN_LSR_IMM, FN_ASR_IMM, FN_LSR_VAR, FN_ASR_VAR, FN_SUB, FN_WRAP_SUB, FN_SHL_IMM,
      6'h2A};
    for (int r = 0; r < 32; r++) begin
      u_rf.regs[r] = rnd();
    end
    u_rf.regs[1] = 32'h80000000;
    u_rf.regs[2] = 32'h00000001;
    u_rf.regs[3] = 32'h7FFFFFFF;
    u_rf.regs[4] = 32'hFFFFFFFF;
    u_rf.regs[5] = 32'hFFFFFFE4;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    `CHK({wr_en_q, done_q, int_ovf_q, foreign_q}, 4'h0)
    // Corner cases, back to back
    issue(1, mk(1, 2, 6, 0, FN_SUB), 0, 0, 1);
    issue(1, mk(3, 4, 7, 0, FN_SUB), 0, 0, 1);
    issue(1, mk(1, 2, 8, 0, FN_WRAP_SUB), 0, 0, 1);
    issue(1, mk(4, 2, 9, 0, FN_SUB), 1, mk(1, 2, 3, 0, FN_WRAP_SUB), 1);
    issue(1, mk(0, 1, 10, 31, FN_ASR_IMM), 1, BRK_WORD, 1);
    issue(1, mk(5, 1, 11, 0, FN_ASR_VAR), 0, 0, 1);
    issue(1, mk(0, 1, 12, 31, FN_LSR_IMM), 0, 0, 1);
    issue(1, mk(5, 4, 13, 0, FN_LSR_VAR), 0, 0, 1);
    issue(1, mk(0, 4, 14, 0, FN_LSR_IMM), 0, 0, 1);
    issue(1, BRK_WORD, 1, mk(1, 2, 3, 0, FN_WRAP_SUB), 1);
    issue(1, BRK_WORD, 1, BRK_WORD, 1);
    issue(1, 32'h00000080, 0, 0, 1);
    issue(1, mk(1, 1, 14, 3, FN_LSR_IMM), 0, 0, 1);
    issue(1, mk(5, 4, 15, 1, FN_LSR_VAR), 0, 0, 1);
    issue(1, mk(2, 1, 16, 1, FN_ASR_IMM), 0, 0, 1);
    issue(1, mk(5, 1, 17, 2, FN_ASR_VAR), 0, 0, 1);
    issue(1, mk(1, 2, 18, 4, FN_SUB), 0, 0, 1);
    // Wrong primary opcode, otherwise a legal wrapping subtract
    issue(1, mk(1, 2, 19, 0, FN_WRAP_SUB) | 32'h04000000, 0, 0, 1);
    issue(1, mk(1, 2, 6, 0, FN_SUB), 1, 0, 0);
    issue(0, 0, 0, 0, 1);
    $display("test corners done");
    // Mid-run reset must clear the result stage at once, without a clock
    @(negedge clk);
    rst_b = 1'b0;
    #1;
    `CHK({result_q, dst_q, wr_en_q, done_q, int_ovf_q, foreign_q}, {RES_RST, DST_RST, 4'h0})
    @(negedge clk);
    rst_b = 1'b1;
    $display("test reset done");
    // Seeded random groups
    for (int n = 0; n < 300; n++) begin
      w = rnd();
      i = rnd();
      i[31:26] = (w[7:0] == 8'h00) ? 6'h01 : 6'h00;
      i[5:0] = fnt[w[10:8]];
      if (w[13:11] != 3'h0) begin
        if (i[5:1] == 5'h01) begin
          i[25:21] = 5'h00;
        end else begin
          i[10:6] = 5'h00;
        end
      end
      if (w[17:14] == 4'h0) begin
        i = BRK_WORD;
      end
      issue(w[18] | w[19], i, w[20], w[21] ? BRK_WORD : rnd(), w[23:22] != 2'h0);
    end
    issue(0, 0, 0, 0, 1);
    $display("test random done");
    end_sim();
  end

  // Hang guard, well past the few hundred cycles of the run
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : issu_unit_tb
